//--- rotu_cfg.svh
// Purpose : named constants for the rotate unit
// Assumes : included by its bare name
// Notes   : definitions only
`ifndef ROTU_CFG_SVH
`define ROTU_CFG_SVH

`define ROTU_DATA_W   16
`define ROTU_MSB8     3'd7
`define ROTU_MSB16    4'd15
`define ROTU_NIB_W    4
`define ROTU_BYTE_W   8
`define ROTU_LSB      0
`define ROTU_W_BIT    3'd0
`define ROTU_CNT_W    8
`define ROTU_CNT_ONE  8'h01
`define ROTU_CNT_ZERO 8'h00

`endif

//--- rotu_core.sv
// Purpose : rotate group datapath and flags, one rotate step per clock
// Assumes : requests come from the execute stage on the same clock
// Notes   : count of zero finishes at once with operand and carry unchanged
//
// How it works
// - a left rotate moves bit 7 or 15 into bit 0 and shifts the rest up one.
// - a left rotate also copies the wrapped top bit into the carry flag.
// - with the low count register or an immediate as source the left rotate step repeats that many times.
// - for the implied count of one (source ROTU_SRC_ONE) the msb change flag is set when the top bit changes and cleared otherwise; any other source clears it.
// - a rotate left through carry loads carry with the top bit on each step.
// - a rotate left through carry puts the old carry into bit 0 on each step.
// - a multi-bit rotate left through carry repeats its step as many times as the count says.
// - a right rotate moves bit 0 into bit 7 or 15 and shifts the rest down one.
// - a right rotate also copies the bit leaving bit 0 into carry.
// - a multi-bit right rotate repeats its step as many times as the count says.
// - the nibble rotate moves dst low to dst high, dst high to accumulator low nibble, accumulator low nibble to dst low.
// - after a nibble rotate the upper nibble of the accumulator lower byte is undefined.
`timescale 1ns/1ns
`include "rotu_cfg.svh"
module rotu_core
   import rotu_pkg::*;
#(
   parameter int DATA_W = `ROTU_DATA_W
)(
   input  wire logic                    sys_clk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    start_i,
   input  wire rotu_op_e                op_i,
   input  wire rotu_src_e               count_src_i,
   input  wire logic [7:0]              opcode_byte_i,
   input  wire logic [`ROTU_CNT_W-1:0]  count_register_low_i,
   input  wire logic [`ROTU_CNT_W-1:0]  imm8_i,
   input  wire logic [DATA_W-1:0]       dst_i,
   input  wire logic [7:0]              accumulator_lower_i,
   input  wire logic                    carry_flag_i,
   output logic                         busy_o,
   output logic                         done_o,
   output logic      [DATA_W-1:0]       result_o,
   output logic      [7:0]              accumulator_lower_o,
   output logic                         carry_flag_o,
   output logic                         msb_change_flag_o,
   output logic                         msb_change_valid_o
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   if (DATA_W != `ROTU_DATA_W) begin : g_bad_width
      $error("rotu_core: only a 16 bit datapath is supported");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic {
      ROTU_ST_IDLE,
      ROTU_ST_RUN
   } rotu_state_e;

   rotu_state_e                 state_q,  state_d;
   rotu_op_e                    op_q,     op_d;
   logic                        wide_q,   wide_d;
   logic                        single_q, single_d;
   logic [`ROTU_CNT_W-1:0]      cnt_q,    cnt_d;
   logic [DATA_W-1:0]           data_q,   data_d;
   logic [7:0]                  acc_q,    acc_d;
   logic                        carry_q,  carry_d;
   logic                        done_q,   done_d;
   logic                        vflag_q,  vflag_d;
   logic                        vvalid_q, vvalid_d;
   logic                        busy_q,   busy_d;

   logic [DATA_W-1:0]           step_data;
   logic                        step_carry;
   logic [`ROTU_CNT_W-1:0]      req_cnt;
   logic                        req_wide;
   logic                        msb_now;
   logic                        msb_next;

   rotu_step u_step (
      .op_i    (op_q),
      .wide_i  (wide_q),
      .data_i  (data_q),
      .carry_i (carry_q),
      .data_o  (step_data),
      .carry_o (step_carry)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      req_wide = opcode_byte_i[`ROTU_W_BIT];
      unique case (count_src_i)
         ROTU_SRC_CNT_LOW: req_cnt = count_register_low_i;
         ROTU_SRC_IMM:     req_cnt = imm8_i;
         default:          req_cnt = `ROTU_CNT_ONE;
      endcase
      msb_now  = wide_q ? data_q[`ROTU_MSB16]    : data_q[`ROTU_MSB8];
      msb_next = wide_q ? step_data[`ROTU_MSB16] : step_data[`ROTU_MSB8];

      state_d  = state_q;
      op_d     = op_q;
      wide_d   = wide_q;
      single_d = single_q;
      cnt_d    = cnt_q;
      data_d   = data_q;
      acc_d    = acc_q;
      carry_d  = carry_q;
      done_d   = 1'b0;
      vflag_d  = vflag_q;
      vvalid_d = vvalid_q;

      unique case (state_q)
         ROTU_ST_IDLE: begin
            if (start_i) begin
               op_d     = op_i;
               wide_d   = req_wide;
               single_d = (count_src_i == ROTU_SRC_ONE);
               cnt_d    = req_cnt;
               data_d   = dst_i;
               acc_d    = accumulator_lower_i;
               carry_d  = carry_flag_i;
               vvalid_d = 1'b0;
               vflag_d  = 1'b0;
               if (op_i == ROTU_OP_NIB) begin
                  // byte operand only; carry untouched
                  data_d = {dst_i[DATA_W-1:`ROTU_BYTE_W], dst_i[`ROTU_NIB_W-1:0],
                            accumulator_lower_i[`ROTU_NIB_W-1:0]};
                  // upper nibble simply kept: software may not rely on it
                  acc_d  = {accumulator_lower_i[7:`ROTU_NIB_W],
                            dst_i[2*`ROTU_NIB_W-1:`ROTU_NIB_W]};
                  done_d = 1'b1;
               end else if (req_cnt == `ROTU_CNT_ZERO) begin
                  done_d = 1'b1;
               end else begin
                  state_d = ROTU_ST_RUN;
               end
            end
         end
         ROTU_ST_RUN: begin
            data_d  = step_data;
            carry_d = step_carry;
            cnt_d   = cnt_q - `ROTU_CNT_ONE;
            if (cnt_q == `ROTU_CNT_ONE) begin
               state_d  = ROTU_ST_IDLE;
               done_d   = 1'b1;
               vvalid_d = single_q;
               vflag_d  = single_q & (msb_now ^ msb_next);
            end
         end
      endcase
      // registered copy so the busy output comes straight from a flop
      busy_d = (state_d == ROTU_ST_RUN);
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q  <= ROTU_ST_IDLE;
         op_q     <= ROTU_OP_ROL;
         wide_q   <= 1'b0;
         single_q <= 1'b0;
         cnt_q    <= `ROTU_CNT_ZERO;
         data_q   <= '0;
         acc_q    <= 8'h00;
         carry_q  <= 1'b0;
         done_q   <= 1'b0;
         vflag_q  <= 1'b0;
         vvalid_q <= 1'b0;
         busy_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         op_q     <= op_d;
         wide_q   <= wide_d;
         single_q <= single_d;
         cnt_q    <= cnt_d;
         data_q   <= data_d;
         acc_q    <= acc_d;
         carry_q  <= carry_d;
         done_q   <= done_d;
         vflag_q  <= vflag_d;
         vvalid_q <= vvalid_d;
         busy_q   <= busy_d;
      end
   end

   assign busy_o              = busy_q;
   assign done_o              = done_q;
   assign result_o            = data_q;
   assign accumulator_lower_o = acc_q;
   assign carry_flag_o        = carry_q;
   assign msb_change_flag_o   = vflag_q;
   assign msb_change_valid_o  = vvalid_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_req_imm3;
      state_q == ROTU_ST_IDLE && start_i && op_i != ROTU_OP_NIB &&
      count_src_i == ROTU_SRC_IMM && imm8_i == 8'h03;
   endsequence

   sequence s_run_three;
      busy_o [*3] ##1 (done_o && !busy_o);
   endsequence

   a_rol_wrap_word: assert property (busy_o && op_q == ROTU_OP_ROL && wide_q |=>
      result_o == {$past(result_o[14:0]), $past(result_o[15])})
      else $error("left rotate word step wrong");

   a_rol_carry_out: assert property (busy_o && op_q == ROTU_OP_ROL && !wide_q |=>
      carry_flag_o == $past(result_o[7]) && result_o[0] == $past(result_o[7]))
      else $error("left rotate carry wrong");

   a_count_imm_len: assert property (s_req_imm3 |=> s_run_three)
      else $error("rotate count length wrong");

   a_msb_change_one: assert property (done_o && msb_change_valid_o && wide_q |->
      msb_change_flag_o == (result_o[15] ^ $past(result_o[15])))
      else $error("msb change flag wrong");

   a_rotate_left_through_carry_op_carry_path: assert property (busy_o && op_q == ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP && !wide_q |=>
      carry_flag_o == $past(result_o[7]) && result_o[0] == $past(carry_flag_o))
      else $error("through carry step wrong");

   a_rotate_left_through_carry_op_count_len: assert property (state_q == ROTU_ST_IDLE && start_i &&
      op_i == ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP && count_src_i == ROTU_SRC_CNT_LOW &&
      count_register_low_i == 8'h02 |=> busy_o ##1 busy_o ##1 done_o)
      else $error("through carry count wrong");

   a_ror_wrap_word: assert property (busy_o && op_q == ROTU_OP_ROR && wide_q |=>
      result_o == {$past(result_o[0]), $past(result_o[15:1])} &&
      carry_flag_o == $past(result_o[0]))
      else $error("right rotate step wrong");

   a_ror_byte_msb: assert property (busy_o && op_q == ROTU_OP_ROR && !wide_q |=>
      result_o[7] == $past(result_o[0]) && carry_flag_o == $past(result_o[0]))
      else $error("right rotate byte wrong");

   a_nib_move: assert property (state_q == ROTU_ST_IDLE && start_i &&
      op_i == ROTU_OP_NIB |=> done_o &&
      result_o[7:0] == {$past(dst_i[3:0]), $past(accumulator_lower_i[3:0])} &&
      accumulator_lower_o[3:0] == $past(dst_i[7:4]))
      else $error("nibble rotate wrong");

   a_size_select: assert property (state_q == ROTU_ST_IDLE && start_i |=>
      wide_q == $past(opcode_byte_i[0]))
      else $error("operand size wrong");

endmodule

//--- rotu_pkg.sv
// Purpose : types shared by the rotate unit files
// Assumes : nothing
// Notes   : operation and count source encodings are internal
package rotu_pkg;

   typedef enum logic [1:0] {
      ROTU_OP_ROL,
      ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP,
      ROTU_OP_ROR,
      ROTU_OP_NIB
   } rotu_op_e;

   typedef enum logic [1:0] {
      ROTU_SRC_ONE,
      ROTU_SRC_CNT_LOW,
      ROTU_SRC_IMM
   } rotu_src_e;

endpackage

//--- rotu_step.sv
// Purpose : one combinational rotate step for 8 or 16 bit operands
// Assumes : op is one of the three bit rotates; nibble op handled by caller
// Notes   : in 8-bit mode the upper byte passes through untouched
`timescale 1ns/1ns
`include "rotu_cfg.svh"
module rotu_step
   import rotu_pkg::*;
(
   input  wire rotu_op_e                  op_i,
   input  wire logic                      wide_i,
   input  wire logic [`ROTU_DATA_W-1:0]   data_i,
   input  wire logic                      carry_i,
   output logic      [`ROTU_DATA_W-1:0]   data_o,
   output logic                           carry_o
);

   logic msb;
   logic lsb;

   always_comb begin
      msb     = wide_i ? data_i[`ROTU_MSB16] : data_i[`ROTU_MSB8];
      lsb     = data_i[`ROTU_LSB];
      data_o  = data_i;
      carry_o = carry_i;
      unique case (op_i)
         ROTU_OP_ROL: begin
            data_o  = {data_i[`ROTU_DATA_W-2:0], msb};
            carry_o = msb;
         end
         ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP: begin
            data_o  = {data_i[`ROTU_DATA_W-2:0], carry_i};
            carry_o = msb;
         end
         ROTU_OP_ROR: begin
            data_o  = {lsb, data_i[`ROTU_DATA_W-1:1]};
            if (!wide_i) begin
               data_o[`ROTU_DATA_W-1:`ROTU_BYTE_W] = data_i[`ROTU_DATA_W-1:`ROTU_BYTE_W];
               data_o[`ROTU_MSB8]                  = lsb;
            end
            carry_o = lsb;
         end
         ROTU_OP_NIB: begin
            data_o  = data_i;
            carry_o = carry_i;
         end
      endcase
      // keep the upper byte for left rotates of a byte operand
      if (!wide_i && op_i != ROTU_OP_ROR) begin
         data_o[`ROTU_DATA_W-1:`ROTU_BYTE_W] = data_i[`ROTU_DATA_W-1:`ROTU_BYTE_W];
      end
   end

endmodule

//--- tb.sv
// Purpose : self-checking bench for the rotate unit, model in integers beside the design
// Assumes : inputs change on the rising edge by non-blocking assignment, outputs read on the falling edge
// Notes   : upper nibble of the accumulator after a nibble rotate is never compared, it is undefined
`timescale 1ns/1ns
`include "rotu_cfg.svh"
module tb
   import rotu_pkg::*;
;
   logic                      sys_clk_i;
   logic                      sys_rst_i;
   logic                      start_i;
   rotu_op_e                  op_i;
   rotu_src_e                 count_src_i;
   logic [7:0]                opcode_byte_i;
   logic [`ROTU_CNT_W-1:0]    count_register_low_i;
   logic [`ROTU_CNT_W-1:0]    imm8_i;
   logic [`ROTU_DATA_W-1:0]   dst_i;
   logic [7:0]                accumulator_lower_i;
   logic                      carry_flag_i;
   logic                      busy_o;
   logic                      done_o;
   logic [`ROTU_DATA_W-1:0]   result_o;
   logic [7:0]                accumulator_lower_o;
   logic                      carry_flag_o;
   logic                      msb_change_flag_o;
   logic                      msb_change_valid_o;
   int                        err_total;
   int                        tests_run;

   rotu_core dut (
      .sys_clk_i            (sys_clk_i),
      .sys_rst_i            (sys_rst_i),
      .start_i              (start_i),
      .op_i                 (op_i),
      .count_src_i          (count_src_i),
      .opcode_byte_i        (opcode_byte_i),
      .count_register_low_i (count_register_low_i),
      .imm8_i               (imm8_i),
      .dst_i                (dst_i),
      .accumulator_lower_i  (accumulator_lower_i),
      .carry_flag_i         (carry_flag_i),
      .busy_o               (busy_o),
      .done_o               (done_o),
      .result_o             (result_o),
      .accumulator_lower_o  (accumulator_lower_o),
      .carry_flag_o         (carry_flag_o),
      .msb_change_flag_o    (msb_change_flag_o),
      .msb_change_valid_o   (msb_change_valid_o)
   );

   always #4 sys_clk_i = ~sys_clk_i;

   // ************************************************************
   // compare and verdict
   // ************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d of %0d compares", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // one operation: model, drive, wait for done, compare
   // ************************************************************
   // poke re-requests while busy; that request must be ignored, so results stay the model's
   // only runs of two or more steps are poked: a shorter one is idle again when the poke lands
   task automatic run_op(input rotu_op_e op, input rotu_src_e src, input bit wide, input int cnt,
                         input logic [15:0] dst, input logic [7:0] acc, input bit cy, input bit poke);
      int          n;
      int          nn;
      int          msb;
      int          lat;
      logic [15:0] mask;
      logic [15:0] v;
      bit          c;
      bit          top;
      bit          seen;
      msb = wide ? 15 : 7;
      mask = wide ? 16'hffff : 16'h00ff;
      nn = (src == ROTU_SRC_ONE) ? 1 : cnt;
      v = dst & mask;
      c = cy;
      if (op != ROTU_OP_NIB) begin
         for (int i = 0; i < nn; i++) begin
            if (op == ROTU_OP_ROR) begin
               top = v[0];
               v = (v >> 1) | (16'(top) << msb);
            end else begin
               top = v[msb];
               v = ((v << 1) | 16'((op == ROTU_OP_ROL) ? top : c)) & mask;
            end
            c = top;
         end
      end
      lat = (op == ROTU_OP_NIB || nn == 0) ? 1 : nn + 1;
      @(posedge sys_clk_i);
      start_i <= 1'b1;
      op_i <= op;
      count_src_i <= src;
      opcode_byte_i <= {7'($urandom), wide};
      count_register_low_i <= (src == ROTU_SRC_CNT_LOW) ? 8'(cnt) : 8'($urandom);
      imm8_i <= (src == ROTU_SRC_IMM) ? 8'(cnt) : 8'($urandom);
      dst_i <= dst;
      accumulator_lower_i <= acc;
      carry_flag_i <= cy;
      n = 0;
      seen = 0;
      while (!seen && n < 300) begin
         @(posedge sys_clk_i);
         start_i <= poke && n == 1 && nn >= 2;
         if (poke && n == 1 && nn >= 2) begin
            op_i <= ROTU_OP_NIB;
            count_src_i <= ROTU_SRC_ONE;
         end
         @(negedge sys_clk_i);
         n++;
         seen = (done_o === 1'b1);
         if (!seen && n == 1) begin
            check(32'(busy_o), 32'h1, "busy");
         end
      end
      check(n, lat, "latency");
      if (op == ROTU_OP_NIB) begin
         check(32'(result_o), {16'h0, dst[15:8], dst[3:0], acc[3:0]}, "nibble result");
         check(32'(accumulator_lower_o[3:0]), 32'(dst[7:4]), "nibble acc");
         check(32'(carry_flag_o), 32'(cy), "nibble carry");
      end else begin
         check(32'(result_o), 32'((dst & ~mask) | v), "result");
         check(32'(carry_flag_o), 32'(c), "carry");
         if (src == ROTU_SRC_ONE) begin
            check(32'({msb_change_valid_o, msb_change_flag_o}), {30'h0, 1'b1, dst[msb] ^ v[msb]}, "msb flag");
         end else begin
            check(32'({msb_change_valid_o, msb_change_flag_o}), 32'h0, "msb flag multi");
         end
      end
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      sys_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      start_i = 1'b0;
      op_i = ROTU_OP_ROL;
      count_src_i = ROTU_SRC_ONE;
      opcode_byte_i = 8'h00;
      count_register_low_i = 8'h00;
      imm8_i = 8'h00;
      dst_i = 16'h0000;
      accumulator_lower_i = 8'h00;
      carry_flag_i = 1'b0;
      err_total = 0;
      tests_run = 0;
      void'($urandom(32'hec8b));
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(negedge sys_clk_i);
      check(32'({busy_o, done_o, carry_flag_o, msb_change_valid_o, result_o}), 32'h0, "reset");
      for (int o = 0; o < 4; o++) begin
         for (int s = 0; s < 3; s++) begin
            for (int w = 0; w < 2; w++) begin
               run_op(rotu_op_e'(o), rotu_src_e'(s), 1'(w), 3, 16'ha5c3, 8'h5e, 1'b1, 1'b0);
            end
         end
      end
      // count boundaries: zero, full 255, and a refused request mid-run
      run_op(ROTU_OP_ROL, ROTU_SRC_IMM, 1'b1, 0, 16'h8001, 8'h00, 1'b1, 1'b0);
      run_op(ROTU_OP_ROR, ROTU_SRC_CNT_LOW, 1'b0, 255, 16'h3c81, 8'h00, 1'b0, 1'b0);
      run_op(ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP, ROTU_SRC_IMM, 1'b1, 17, 16'hc001, 8'h00, 1'b0, 1'b1);
      run_op(ROTU_OP_ROTATE_LEFT_THROUGH_CARRY_OP, ROTU_SRC_CNT_LOW, 1'b0, 2, 16'h1281, 8'h00, 1'b1, 1'b1);
      repeat (300) begin
         run_op(rotu_op_e'($urandom_range(3)), rotu_src_e'($urandom_range(2)), 1'($urandom),
                $urandom_range(20), 16'($urandom), 8'($urandom), 1'($urandom), $urandom_range(7) == 0);
      end
      tally_and_finish;
   end

   // hang guard: far beyond the few thousand cycles the sequence needs
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      err_total++;
      tally_and_finish;
   end
endmodule
